/* bench/plc_model.sv */
`timescale 1ns/10ps
// ****************************************
// Controller side of the discrete lines
// ****************************************
module plc_model #(
  parameter int SETTLE_CYC = 20
) (
  // Clock
  input  wire logic       clk_i,
  // Edge lines and position number lines toward the positioner
  output logic            alarm_clear_in_o,
  output logic            move_start_in_o,
  output logic [8:0]      cmd_pos_o,
  output logic [6:0]      direct_move_in_o
);
  // Idle levels from time zero
  initial begin
    alarm_clear_in_o = 1'b0;
    move_start_in_o  = 1'b0;
    cmd_pos_o        = 9'h000;
    direct_move_in_o = 7'h00;
  end

  // Number first, start later; number then flips so a late sample cannot pass
  task automatic start_move(input logic [8:0] pos);
    @(posedge clk_i);
    cmd_pos_o <= pos;
    repeat (SETTLE_CYC) @(posedge clk_i);
    move_start_in_o <= 1'b1;
    repeat (6) @(posedge clk_i);
    move_start_in_o <= 1'b0;
    cmd_pos_o       <= ~pos;
    repeat (4) @(posedge clk_i);
  endtask

  // One direct command, held long enough for the synchroniser
  task automatic direct_move(input int n);
    @(posedge clk_i);
    direct_move_in_o[n] <= 1'b1;
    repeat (6) @(posedge clk_i);
    direct_move_in_o[n] <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask

  // Alarm clear pulse
  task automatic pulse_clear();
    @(posedge clk_i);
    alarm_clear_in_o <= 1'b1;
    repeat (6) @(posedge clk_i);
    alarm_clear_in_o <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
endmodule

/* bench/test_pio_handshake.sv */
`timescale 1ns/10ps
// ****************************************
// Self-checking bench
// ****************************************
module test_pio_handshake;
  import pio_handshake_pkg::*;
  logic        clk_i, rstn_i, ce_i, avs_read_i, avs_write_i, avs_waitrequest_o;
  logic [3:0]  avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, rd;
  logic        alarm_clear, move_start, servo_req, pause_n, brake_req, mode_sel;
  logic [8:0]  cmd_pos, done_pos_o, move_pos_o, pulse_pos, pulse_done;
  logic [6:0]  direct_move;
  logic        mode_status_out_o, homing_done_out_o, positioning_done_out_o, ready_out_o;
  logic        estop_status_n_o, alarm_n_o, load_judge_out_o, torque_level_out_o;
  logic        servo_on_o, brake_release_o, motion_permit_o, manual_mode_o, move_pulse_o;
  int          n_mismatch, samples_checked, cyc, pulses, p0;
  localparam logic [31:0] RUN = 32'h1 << CTRL_CAN_RUN;

  pio_handshake DUT (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .alarm_clear_in_i(alarm_clear),
    .servo_request_in_i(servo_req), .move_start_in_i(move_start), .pause_n_i(pause_n),
    .cmd_pos_i(cmd_pos), .direct_move_in_i(direct_move), .brake_release_in_i(brake_req),
    .mode_select_in_i(mode_sel), .done_pos_o(done_pos_o),
    .mode_status_out_o(mode_status_out_o), .homing_done_out_o(homing_done_out_o),
    .positioning_done_out_o(positioning_done_out_o), .ready_out_o(ready_out_o),
    .estop_status_n_o(estop_status_n_o), .alarm_n_o(alarm_n_o),
    .load_judge_out_o(load_judge_out_o), .torque_level_out_o(torque_level_out_o),
    .servo_on_o(servo_on_o), .brake_release_o(brake_release_o),
    .motion_permit_o(motion_permit_o), .manual_mode_o(manual_mode_o),
    .move_pulse_o(move_pulse_o), .move_pos_o(move_pos_o));

  plc_model #(.SETTLE_CYC(20)) plc (.clk_i(clk_i), .alarm_clear_in_o(alarm_clear),
    .move_start_in_o(move_start), .cmd_pos_o(cmd_pos), .direct_move_in_o(direct_move));

  // Clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Pulse monitor and hang guard; 20000 cycles is about fifty times the expected run of some 400 cycles
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (move_pulse_o === 1'b1) begin
      pulses     <= pulses + 1;
      pulse_pos  <= move_pos_o;
      pulse_done <= done_pos_o;
    end
    if (cyc == 20000) begin
      n_mismatch++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Pin comparison
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One bus access; read data taken at the edge where waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    avs_address_i   <= a;
    avs_writedata_i <= d;
    avs_write_i     <= wr;
    avs_read_i      <= ~wr;
    do begin
      @(posedge clk_i);
    end while (avs_waitrequest_o !== 1'b0);
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
  endtask

  // Register read comparison
  task automatic check_reg(input string what, input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(what, exp, rd);
  endtask

  // Settle time for level paths
  task automatic settle();
    repeat (8) @(posedge clk_i);
  endtask

  // Start a move and compare the pulse that follows
  task automatic move(input logic [8:0] pos, input int exp_n);
    p0 = pulses;
    plc.start_move(pos);
    repeat (4) @(posedge clk_i);
    check("start pulses", 32'(exp_n), 32'(pulses - p0));
  endtask

  // Main sequence
  initial begin
    rstn_i = 1'b0; ce_i = 1'b1; avs_read_i = 1'b0; avs_write_i = 1'b0;
    avs_address_i = 4'h0; avs_writedata_i = 32'h0; servo_req = 1'b0; pause_n = 1'b1;
    brake_req = 1'b0; mode_sel = 1'b0; n_mismatch = 0; samples_checked = 0; cyc = 0;
    pulses = 0;
    repeat (10) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    check("estop_n reset", 32'h1, 32'(estop_status_n_o));
    check("alarm_n reset", 32'h1, 32'(alarm_n_o));
    check("homed reset", 32'h0, 32'(homing_done_out_o));
    check_reg("ctrl reset", ADDR_CTRL, CTRL_RESET);
    // Servo, ready, mode and brake levels
    servo_req <= 1'b1;
    bus(1'b1, ADDR_CTRL, RUN | 32'(PAT_512PT));
    settle();
    check("servo on", 32'h1, 32'(servo_on_o));
    check("ready", 32'h1, 32'(ready_out_o));
    servo_req <= 1'b0;
    settle();
    check("servo off", 32'h0, 32'(servo_on_o));
    check("ready off", 32'h0, 32'(ready_out_o));
    servo_req <= 1'b1;
    mode_sel  <= 1'b1;
    brake_req <= 1'b1;
    settle();
    check("mode status", 32'h1, 32'(mode_status_out_o));
    check("manual", 32'h1, 32'(manual_mode_o));
    check("brake", 32'h1, 32'(brake_release_o));
    mode_sel  <= 1'b0;
    brake_req <= 1'b0;
    settle();
    check("auto status", 32'h0, 32'(mode_status_out_o));
    check("brake held", 32'h0, 32'(brake_release_o));
    // Binary numbered moves
    move(9'h1a5, 1);
    check("move pos", 32'h1a5, 32'(pulse_pos));
    bus(1'b1, ADDR_CTRL, RUN | 32'(PAT_512PT) | (32'h3 << CTRL_ARRIVED));
    settle();
    check("done pos", 32'h1a5, 32'(done_pos_o));
    check("pos done", 32'h1, 32'(positioning_done_out_o));
    move(9'h0ff, 1);
    check("done at start", 32'h0, 32'(pulse_done));
    check("done after", 32'h0, 32'(done_pos_o));
    check("move pos 2", 32'h0ff, 32'(pulse_pos));
    check_reg("cmd reg", ADDR_CMD, 32'h0ff);
    pause_n <= 1'b0;
    settle();
    check("permit", 32'h0, 32'(motion_permit_o));
    move(9'h003, 0);
    pause_n <= 1'b1;
    // Direct commands
    bus(1'b1, ADDR_CTRL, RUN | 32'(PAT_DIRECT));
    for (int n = 0; n < 7; n++) begin
      p0 = pulses;
      plc.direct_move(n);
      repeat (4) @(posedge clk_i);
      check("direct pulses", 32'h1, 32'(pulses - p0));
      check("direct pos", 32'(n), 32'(pulse_pos));
    end
    move(9'h005, 0);
    // Status feeds from the motion core
    bus(1'b1, ADDR_CTRL, 32'h0e90 | 32'(PAT_DIRECT));
    settle();
    check("homed", 32'h1, 32'(homing_done_out_o));
    check("estop_n", 32'h0, 32'(estop_status_n_o));
    check("load", 32'h1, 32'(load_judge_out_o));
    check("torque", 32'h1, 32'(torque_level_out_o));
    check_reg("ctrl back", ADDR_CTRL, 32'h0e94);
    check_reg("unmapped", 4'h2, 32'h0);
    check_reg("event reg", ADDR_EVENT, 32'h6);
    bus(1'b1, ADDR_CTRL, (32'h1 << CTRL_TRQ_OVER) | (32'h1 << CTRL_FAULT));
    settle();
    check("load out", 32'h0, 32'(load_judge_out_o));
    check("homed sticky", 32'h1, 32'(homing_done_out_o));
    check("estop_n clear", 32'h1, 32'(estop_status_n_o));
    check("alarm_n", 32'h0, 32'(alarm_n_o));
    // Alarm is latched until the clear edge
    bus(1'b1, ADDR_CTRL, RUN | 32'(PAT_DIRECT));
    settle();
    check("alarm_n held", 32'h0, 32'(alarm_n_o));
    plc.pulse_clear();
    settle();
    check("alarm_n cleared", 32'h1, 32'(alarm_n_o));
    check_reg("status reg", ADDR_STATUS, 32'h2e);
    // Clock enable low must freeze the servo path even as the request falls
    ce_i      <= 1'b0;
    servo_req <= 1'b0;
    settle();
    check("servo frozen", 32'h1, 32'(servo_on_o));
    ce_i <= 1'b1;
    settle();
    check("servo released", 32'h0, 32'(servo_on_o));
    close_out();
  end
endmodule

/* rtl/pio_handshake.sv */
// The Avalon-MM slave port and the address map are this design's own decisions.
`timescale 1ns/10ps
// Notes on behaviour
// - alarm clears on alarm clear rising edge
// - servo drive follows servo request level
// - reached position shown on binary lines
// - position lines cleared on accepted start
// - mode status low auto, high manual
// - homing done low from reset, set after homing
// - done output when reached and in band
// - ready when servo on and able
// - estop status low during emergency stop
// - alarm output low on any alarm
// - load flag when torque high in range
// - torque flag when current reaches threshold
// - direct input n rising starts move n
// - brake released while release input high
// - operating mode follows mode select level
// - pattern four selects direct inputs
// - pattern three selects binary number inputs
// - start rising edge begins commanded move
// - pause low decelerates, high permits motion
module pio_handshake
  import pio_handshake_pkg::*;
#(
  parameter int DIRECT_POINTS = 7
) (
  // Clock, reset, enable
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        ce_i,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  // PLC inputs
  input  wire logic        alarm_clear_in_i,
  input  wire logic        servo_request_in_i,
  input  wire logic        move_start_in_i,
  input  wire logic        pause_n_i,
  input  wire logic [8:0]  cmd_pos_i,
  input  wire logic [6:0]  direct_move_in_i,
  input  wire logic        brake_release_in_i,
  input  wire logic        mode_select_in_i,
  // PLC outputs
  output logic      [8:0]  done_pos_o,
  output logic             mode_status_out_o,
  output logic             homing_done_out_o,
  output logic             positioning_done_out_o,
  output logic             ready_out_o,
  output logic             estop_status_n_o,
  output logic             alarm_n_o,
  output logic             load_judge_out_o,
  output logic             torque_level_out_o,
  // Drive controls toward the motion core
  output logic             servo_on_o,
  output logic             brake_release_o,
  output logic             motion_permit_o,
  output logic             manual_mode_o,
  output logic             move_pulse_o,
  output logic      [8:0]  move_pos_o
);

  // Elaboration check: the direct index is three bits and seven lines wide
  if (DIRECT_POINTS < 1 || DIRECT_POINTS > 7) begin : g_bad_points
    $error("DIRECT_POINTS must be 1 to 7");
  end

  // ****************************************
  // Input synchronisers
  // ****************************************
  localparam int NSYNC = 12;
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] sync1;
  logic [NSYNC-1:0] sync2;
  logic [NSYNC-1:0] prev;
  logic [NSYNC-1:0] rise;

  assign raw_in = {brake_release_in_i, mode_select_in_i, pause_n_i, servo_request_in_i,
                   alarm_clear_in_i, move_start_in_i, direct_move_in_i[5:0]};

  // Two flops per line; only the second stage and its delayed copy feed logic
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      sync1 <= '0;
      sync2 <= '0;
      prev  <= '0;
    end else if (ce_i) begin
      sync1 <= raw_in;
      sync2 <= sync1;
      prev  <= sync2;
    end
  end

  // Rising edge only after a registered low then a registered high
  assign rise = sync2 & ~prev;

  // Seventh direct line kept on its own flops to keep the bundle narrow
  logic d6_s1;
  logic d6_s2;
  logic d6_prev;
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      d6_s1   <= 1'b0;
      d6_s2   <= 1'b0;
      d6_prev <= 1'b0;
    end else if (ce_i) begin
      d6_s1   <= direct_move_in_i[6];
      d6_s2   <= d6_s1;
      d6_prev <= d6_s2;
    end
  end

  logic [6:0] direct_rise;
  assign direct_rise = {d6_s2 & ~d6_prev, rise[5:0]};

  // Position lines are levels settled well before start, so one sample stage suffices
  logic [8:0] cmd_pos_q;
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cmd_pos_q <= '0;
    end else if (ce_i) begin
      cmd_pos_q <= cmd_pos_i;
    end
  end

  logic start_rise;
  logic clear_rise;
  logic servo_req;
  logic pause_ok;
  logic mode_sel;
  logic brake_req;
  assign start_rise = rise[6];
  assign clear_rise = rise[7];
  assign servo_req  = sync2[8];
  assign pause_ok   = sync2[9];
  assign mode_sel   = sync2[10];
  assign brake_req  = sync2[11];

  // ****************************************
  // Control register
  // ****************************************
  logic [31:0] ctrl;
  logic [31:0] next_ctrl;
  logic [2:0]  pattern;
  logic        bus_wr;

  assign pattern = ctrl[CTRL_PAT_LSB +: 3];
  assign bus_wr  = ce_i && avs_write_i && avs_waitrequest_o == 1'b0;

  // Software loads pattern and motion core status bits
  always_comb begin
    next_ctrl = ctrl;
    if (bus_wr && avs_address_i == ADDR_CTRL) begin
      next_ctrl = avs_writedata_i & 32'h0000_1ff7;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      ctrl <= CTRL_RESET;
    end else if (ce_i) begin
      ctrl <= next_ctrl;
    end
  end

  // ****************************************
  // Move command, alarm and output state
  // ****************************************
  move_cmd_t cmd;
  move_cmd_t next_cmd;
  plc_out_t  outs;
  plc_out_t  next_outs;
  logic      alarm;
  logic      next_alarm;
  logic      homed;
  logic      next_homed;
  logic      arrived_q;
  logic      ctl_q;
  logic [3:0] drv_q;
  logic [3:0] next_drv;
  logic [2:0] dir_idx;

  // Lowest numbered direct edge wins when several rise together
  always_comb begin
    dir_idx = 3'h0;
    for (int i = DIRECT_POINTS - 1; i >= 0; i--) begin
      if (direct_rise[i]) begin
        dir_idx = 3'(i);
      end
    end
  end

  always_comb begin
    next_cmd   = '0;
    next_alarm = alarm;
    next_homed = homed;
    next_outs  = outs;
    // Latched alarm; a new fault beats a clearing edge
    if (clear_rise) begin
      next_alarm = 1'b0;
    end
    if (ctrl[CTRL_FAULT]) begin
      next_alarm = 1'b1;
    end
    if (ctrl[CTRL_HOMED]) begin
      next_homed = 1'b1;
    end
    // Start requests are taken only while running is permitted
    if (pattern == PAT_512PT && start_rise && pause_ok && !alarm) begin
      next_cmd.move_pulse = 1'b1;
      next_cmd.move_pos   = cmd_pos_q;
    end else if (pattern == PAT_DIRECT && (|direct_rise[DIRECT_POINTS-1:0])
                 && pause_ok && !alarm) begin
      next_cmd.move_pulse = 1'b1;
      next_cmd.move_pos   = {6'h00, dir_idx};
    end
    // Arrival rising edge in the binary pattern latches the reached number; a new start clears it
    if (next_cmd.move_pulse) begin
      next_outs.done_pos = '0;
    end else if (ctrl[CTRL_ARRIVED] && !arrived_q && pattern == PAT_512PT) begin
      next_outs.done_pos = cmd.move_pos;
    end
    next_outs.mode_status      = mode_sel;
    next_outs.homing_done      = next_homed;
    next_outs.positioning_done = ctrl[CTRL_ARRIVED] && ctrl[CTRL_INBAND];
    next_outs.ready            = servo_req && ctrl[CTRL_CAN_RUN];
    next_outs.estop_status_n   = !ctrl[CTRL_ESTOP];
    next_outs.alarm_n          = !next_alarm;
    next_outs.load_judge       = ctrl[CTRL_TRQ_OVER] && ctrl[CTRL_IN_RANGE];
    next_outs.torque_level     = ctrl[CTRL_CUR_REACH];
    // Drive controls: servo, brake, pause permit, manual mode
    next_drv = {servo_req, brake_req, pause_ok, mode_sel};
  end

  // Position last commanded, held for reporting at arrival
  logic [8:0] held_pos;
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      held_pos <= '0;
    end else if (ce_i && next_cmd.move_pulse) begin
      held_pos <= next_cmd.move_pos;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cmd       <= '0;
      alarm     <= 1'b0;
      homed     <= 1'b0;
      outs      <= '{default: '0, estop_status_n: 1'b1, alarm_n: 1'b1};
      arrived_q <= 1'b0;
      drv_q     <= '0;
      ctl_q     <= 1'b0;
    end else if (ce_i) begin
      cmd       <= '{move_pulse: next_cmd.move_pulse,
                     move_pos: next_cmd.move_pulse ? next_cmd.move_pos : held_pos};
      alarm     <= next_alarm;
      homed     <= next_homed;
      outs      <= next_outs;
      arrived_q <= ctrl[CTRL_ARRIVED];
      drv_q     <= next_drv;
      ctl_q     <= next_cmd.move_pulse;
    end
  end

  // ****************************************
  // Output pins, all straight from flops
  // ****************************************
  assign done_pos_o             = outs.done_pos;
  assign mode_status_out_o      = outs.mode_status;
  assign homing_done_out_o      = outs.homing_done;
  assign positioning_done_out_o = outs.positioning_done;
  assign ready_out_o            = outs.ready;
  assign estop_status_n_o       = outs.estop_status_n;
  assign alarm_n_o              = outs.alarm_n;
  assign load_judge_out_o       = outs.load_judge;
  assign torque_level_out_o     = outs.torque_level;
  assign servo_on_o             = drv_q[3];
  assign brake_release_o        = drv_q[2];
  assign motion_permit_o        = drv_q[1];
  assign manual_mode_o          = drv_q[0];
  assign move_pulse_o           = cmd.move_pulse;
  assign move_pos_o             = cmd.move_pos;

  // ****************************************
  // Bus answer: one wait cycle per access
  // ****************************************
  logic        wait_q;
  logic [31:0] rdata_q;
  logic [31:0] next_rdata;

  // Read data captured in the wait cycle, so they stand when waitrequest drops
  always_comb begin
    next_rdata = rdata_q;
    if (avs_read_i && wait_q) begin
      unique case (avs_address_i)
        ADDR_CTRL:   next_rdata = ctrl;
        ADDR_STATUS: next_rdata = {16'h0000, outs.done_pos, outs.mode_status, outs.homing_done,
                                   outs.positioning_done, outs.ready, outs.estop_status_n,
                                   outs.alarm_n, alarm};
        ADDR_CMD:    next_rdata = {22'h000000, ctl_q, cmd.move_pos};
        ADDR_EVENT:  next_rdata = {29'h00000000, homed, pattern == PAT_DIRECT,
                                   pattern == PAT_512PT};
        default:     next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // Waitrequest high at rest, dropped for one cycle once a request is seen
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      wait_q  <= 1'b1;
      rdata_q <= '0;
    end else if (ce_i) begin
      wait_q  <= !(wait_q && (avs_read_i || avs_write_i));
      rdata_q <= next_rdata;
    end
  end

  assign avs_waitrequest_o = wait_q;
  assign avs_readdata_o    = rdata_q;

  // ****************************************
  // Checks
  // ****************************************
  start_takes_move_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ce_i && pattern == PAT_512PT && start_rise && pause_ok && !alarm |=> move_pulse_o)
    else $error("start edge did not start a move");
  start_clears_pos_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ce_i && next_cmd.move_pulse |=> done_pos_o == 9'h000)
    else $error("position lines not cleared on start");
  alarm_clears_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ce_i && clear_rise && !ctrl[CTRL_FAULT] |=> alarm_n_o)
    else $error("alarm not cleared by clear edge");
  alarm_raised_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ce_i && ctrl[CTRL_FAULT] |=> !alarm_n_o)
    else $error("alarm output not pulled low");
  homing_sticks_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    homing_done_out_o |=> homing_done_out_o)
    else $error("homing done fell");
  direct_pos_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ce_i && pattern == PAT_DIRECT && direct_rise[0] && pause_ok && !alarm
    |=> move_pulse_o && move_pos_o == 9'h000)
    else $error("direct input 0 misrouted");
  edge_needs_low_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    start_rise |-> !$past(sync2[6]) || !$past(ce_i))
    else $error("edge without low sample");
  servo_follows_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ce_i && servo_req |=> servo_on_o)
    else $error("servo drive not following request");

endmodule

/* rtl/pio_handshake_pkg.sv */
package pio_handshake_pkg;

  // ****************************************
  // Pattern selection codes
  // ****************************************
  localparam logic [2:0] PAT_512PT  = 3'h3;
  localparam logic [2:0] PAT_DIRECT = 3'h4;

  // ****************************************
  // Register map, word byte addresses
  // ****************************************
  localparam logic [3:0] ADDR_CTRL   = 4'h0;  // Pattern, status feeds from motion core
  localparam logic [3:0] ADDR_STATUS = 4'h4;  // Outputs and alarm latch
  localparam logic [3:0] ADDR_CMD    = 4'h8;  // Pending move command and position
  localparam logic [3:0] ADDR_EVENT  = 4'hc;  // Event reporting: homed flag and pattern decode, read only

  // Control field positions
  localparam int CTRL_PAT_LSB   = 0;
  localparam int CTRL_HOMED     = 4;
  localparam int CTRL_ARRIVED   = 5;
  localparam int CTRL_INBAND    = 6;
  localparam int CTRL_ESTOP     = 7;
  localparam int CTRL_FAULT     = 8;
  localparam int CTRL_TRQ_OVER  = 9;
  localparam int CTRL_IN_RANGE  = 10;
  localparam int CTRL_CUR_REACH = 11;
  localparam int CTRL_CAN_RUN   = 12;

  // Reset values
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [2:0]  PAT_RESET  = 3'h0;

  // Synchroniser depth, counted in flip-flops
  localparam int SYNC_STAGES = 2;

  // Command settle time before start, in ms, and in clock cycles
  localparam int CLK_MHZ        = 100;
  localparam int SETTLE_MS      = 6;
  localparam int SETTLE_CYCLES  = SETTLE_MS * 1000 * CLK_MHZ;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic       move_pulse;
    logic [8:0] move_pos;
  } move_cmd_t;

  typedef struct packed {
    logic [8:0] done_pos;
    logic       mode_status;
    logic       homing_done;
    logic       positioning_done;
    logic       ready;
    logic       estop_status_n;
    logic       alarm_n;
    logic       load_judge;
    logic       torque_level;
  } plc_out_t;

endpackage
